// [src/estop_pkg.sv]
`default_nettype none

package estop_pkg;

    // ==================================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int DEBOUNCE_TIME_US = 1000;
    // least time, so round up to whole cycles
    localparam int DEBOUNCE_CYCLES =
        (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sync and level flops ahead of the hold counter, with spare cycles
    localparam int SETTLE_MARGIN = 8;

    // ==================================================================
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'h1;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h2;
    localparam logic [3:0] REG_LIVE_STATE = 4'h3;
    localparam logic [3:0] REG_SWITCHES = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h5;
    localparam int CTRL_SOFT_STOP = 0;
    localparam logic CONTROL_SOFT_STOP_RST = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==================================================================
    // events and interrupt
    localparam int EVENT_W = 4;
    localparam int EV_POWER_LOST = 0;
    localparam int EV_POWER_BACK = 1;
    localparam int EV_UNDER_VOLT = 2;
    localparam int EV_RESET_REJECT = 3;
    localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;
    localparam logic [3:0] IRQ_STATUS_RST = 4'h0;

    // ==================================================================
    // live state bits
    localparam int LS_MOTOR_POWER = 0;
    localparam int LS_STOP_ACTIVE = 1;
    localparam int LS_INT_CLOSED = 2;
    localparam int LS_EXT_CLOSED = 3;
    localparam int LS_UNDER_VOLT = 4;
    localparam int LS_RELAY_CLOSED = 5;
    localparam int LS_BRAKE_ONE = 6;
    localparam int LS_BRAKE_TWO = 7;

    // ==================================================================
    // configuration switch bank positions
    localparam int SW_W = 8;
    localparam int SW_RESET_CFG = 0;
    localparam int SW_BRAKE_POL = 1;
    localparam int SW_LOGIC_CFG = 2;
    localparam int SW_RELAY_CFG = 3;
    localparam int SW_INT_STOP = 4;
    localparam int SW_EXT_STOP = 5;
    localparam int SW_UV_MON = 6;

    // ==================================================================
    // filtered input vector positions
    localparam int IN_INT = 0;
    localparam int IN_EXT = 1;
    localparam int IN_RESET = 2;
    localparam int IN_BRAKE_ONE_DRIVE = 3;
    localparam int IN_BRAKE_TWO_DRIVE = 4;
    localparam int IN_RELAY = 5;
    localparam int IN_UV = 6;
    localparam int IN_SW0 = 7;
    localparam int IN_W = 14;

    // ==================================================================
    // stop state machine
    typedef enum logic [2:0] {
        ST_STOPPED = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN = 3'b100
    } fsm_t;
    localparam fsm_t FSM_RST = ST_STOPPED;

endpackage : estop_pkg

`default_nettype wire

// [src/input_filter.sv]
`default_nettype none

module input_filter
    import estop_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYCLES,
    parameter bit FAST_FALL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic din,
    output logic stable
);

    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic stable;
        logic [CW-1:0] cnt;
    } filt_t;

    filt_t q;
    filt_t next_q;

    // ==================================================================
    // three-flop sync, then a hold-off counter before a change is taken
    always_comb begin
        next_q = q;
        next_q.s1 = din;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        if (q.s2 == q.s3) begin
            next_q.level = q.s3;
        end
        // a loop opening must not wait out the bounce window
        if (FAST_FALL && !q.level) begin
            next_q.stable = 1'b0;
            next_q.cnt = '0;
        end else if (q.level != q.stable) begin
            if (q.cnt == CW'(CYCLES - 1)) begin
                next_q.stable = q.level;
                next_q.cnt = '0;
            end else begin
                next_q.cnt = q.cnt + CW'(1);
            end
        end else begin
            next_q.cnt = '0; // bounce restarts the window
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign stable = q.stable;

    property p_rise_after_hold;
        @(posedge clk) disable iff (!rst_n || !ce)
        $rose(q.stable) |-> $past(q.level) && q.level;
    endproperty
    a_rise_after_hold: assert property (p_rise_after_hold)
        else $error("filtered level rose without a settled input");

endmodule : input_filter

`default_nettype wire

// [src/event_irq.sv]
`default_nettype none

module event_irq
    import estop_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [EVENT_W-1:0] event_in,
    input wire logic clear_wr,
    input wire logic enable_wr,
    input wire logic [EVENT_W-1:0] wdata,
    output logic [EVENT_W-1:0] status,
    output logic [EVENT_W-1:0] enable,
    output logic irq
);

    typedef struct packed {
        logic [EVENT_W-1:0] status;
        logic [EVENT_W-1:0] enable;
    } irq_state_t;

    irq_state_t q;
    irq_state_t next_q;

    // ==================================================================
    // sticky status; an event in the clearing cycle survives the clear
    always_comb begin
        next_q = q;
        if (clear_wr) begin
            next_q.status = q.status & ~wdata;
        end
        next_q.status = next_q.status | event_in;
        if (enable_wr) begin
            next_q.enable = wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.status <= IRQ_STATUS_RST;
            q.enable <= IRQ_ENABLE_RST;
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign status = q.status;
    assign enable = q.enable;
    // level output, built from flops only
    assign irq = |(q.status & q.enable);

    property p_set_wins;
        @(posedge clk) disable iff (!rst_n || !ce)
        (|event_in) |=> ((status & $past(event_in)) == $past(event_in));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against a simultaneous clear");

endmodule : event_irq

`default_nettype wire

// [src/estop_brake_interlock.sv]
// Chosen here: the placing of the registers and the plain strobed port.
`default_nettype none

module estop_brake_interlock
    import estop_pkg::*;
#(
    parameter int FILTER_CYCLES = DEBOUNCE_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    input wire logic INTERNAL_STOP_LOOP,
    input wire logic EXTERNAL_STOP_LOOP,
    input wire logic STOP_RESET_CLOSURE,
    input wire logic BRAKE_ONE_REQUEST,
    input wire logic BRAKE_TWO_REQUEST,
    input wire logic RELAY_CONTROL,
    input wire logic UNDER_VOLTAGE_SENSE,
    input wire logic [SW_W-1:0] CONFIG_SWITCH_BANK,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic MOTOR_POWER,
    output logic STOP_STATE_LOGIC_OUT,
    output logic RELAY_CLOSE,
    output logic BRAKE_ONE_DRIVE,
    output logic BRAKE_TWO_DRIVE,
    output logic UNDER_VOLTAGE_FLAG,
    output logic IRQ
);

    // ==================================================================
    // reset release through two flops; assertion stays asynchronous
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==================================================================
    // input filtering
    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] filt;

    // every pin arrives asynchronously, switches included
    assign raw_in = {CONFIG_SWITCH_BANK[SW_UV_MON:0],
                     UNDER_VOLTAGE_SENSE, RELAY_CONTROL,
                     BRAKE_TWO_REQUEST, BRAKE_ONE_REQUEST,
                     STOP_RESET_CLOSURE, EXTERNAL_STOP_LOOP,
                     INTERNAL_STOP_LOOP};

    // stop loops drop at once, every other input waits out bounce
    for (genvar i = 0; i < IN_W; i++) begin : g_filter
        input_filter #(
            .CYCLES(FILTER_CYCLES),
            .FAST_FALL(i <= IN_EXT)
        ) u_filter (
            .clk(SYS_CLK),
            .rst_n(rst_n),
            .ce(CLK_EN),
            .din(raw_in[i]),
            .stable(filt[i])
        );
    end

    logic int_ok;
    logic ext_ok;
    logic reset_closed;
    logic brake_one_req;
    logic brake_two_req;
    logic relay_req;
    logic uv_seen;
    logic [SW_W-1:0] sw;

    assign int_ok = filt[IN_INT];
    assign ext_ok = filt[IN_EXT];
    assign reset_closed = filt[IN_RESET];
    assign brake_one_req = filt[IN_BRAKE_ONE_DRIVE];
    assign brake_two_req = filt[IN_BRAKE_TWO_DRIVE];
    assign relay_req = filt[IN_RELAY];
    assign uv_seen = filt[IN_UV];
    assign sw = {1'b0, filt[IN_W-1:IN_SW0]};

    // ==================================================================
    // block state
    localparam int SETTLE_W = $clog2(FILTER_CYCLES + SETTLE_MARGIN + 1);
    typedef struct packed {
        fsm_t fsm;
        logic reset_prev;
        logic [SETTLE_W-1:0] settle;
        logic soft_stop;
        logic motor_power;
        logic logic_out;
        logic relay_close;
        logic brake_one;
        logic brake_two;
        logic uv_flag;
        logic [DATA_W-1:0] rdata;
    } top_state_t;

    top_state_t q;
    top_state_t next_q;

    logic open_now;
    logic all_closed;
    logic settled;
    logic reset_rise;
    logic [EVENT_W-1:0] events;
    logic [EVENT_W-1:0] irq_status;
    logic [EVENT_W-1:0] irq_enable;
    logic [DATA_W-1:0] live_state;
    logic clear_wr;
    logic enable_wr;

    // ==================================================================
    // stop conditions from the enabled loops and the software stop
    always_comb begin
        open_now = q.soft_stop || !settled; // held stopped until the switches have settled
        all_closed = !q.soft_stop && settled;
        if (sw[SW_INT_STOP]) begin
            open_now = open_now || !int_ok;
            all_closed = all_closed && int_ok;
        end
        if (sw[SW_EXT_STOP]) begin
            open_now = open_now || !ext_ok;
            all_closed = all_closed && ext_ok;
        end
    end

    assign reset_rise = reset_closed && !q.reset_prev;
    assign settled = (q.settle == SETTLE_W'(FILTER_CYCLES + SETTLE_MARGIN));

    // ==================================================================
    // stop state machine, outputs, events and register writes
    always_comb begin
        next_q = q;
        events = '0;
        next_q.reset_prev = reset_closed;
        next_q.settle = settled ? q.settle : q.settle + SETTLE_W'(1);
        case (q.fsm)
            ST_STOPPED: begin
                if (open_now) begin
                    next_q.fsm = ST_STOPPED;
                end else if (all_closed && sw[SW_RESET_CFG]) begin
                    next_q.fsm = ST_ARMED;
                end else if (all_closed) begin
                    next_q.fsm = ST_RUN;
                end
                // a closure while still stopped is not remembered
                if (reset_rise) begin
                    events[EV_RESET_REJECT] = 1'b1;
                end
            end
            ST_ARMED: begin
                if (open_now) begin
                    next_q.fsm = ST_STOPPED;
                end else if (!sw[SW_RESET_CFG]) begin
                    next_q.fsm = ST_RUN;
                end else if (reset_rise) begin
                    next_q.fsm = ST_RUN;
                end
            end
            ST_RUN: begin
                if (open_now) begin
                    next_q.fsm = ST_STOPPED;
                end
                if (reset_rise) begin
                    events[EV_RESET_REJECT] = 1'b1;
                end
            end
            default: begin
                next_q.fsm = ST_STOPPED; // illegal code: fail safe
            end
        endcase

        next_q.motor_power = (next_q.fsm == ST_RUN);
        if (q.motor_power && !next_q.motor_power) begin
            events[EV_POWER_LOST] = 1'b1;
        end
        if (!q.motor_power && next_q.motor_power) begin
            events[EV_POWER_BACK] = 1'b1;
        end

        // stop output header: logic level and relay contacts
        next_q.logic_out = sw[SW_LOGIC_CFG] && next_q.motor_power;
        next_q.relay_close = relay_req
            && !(sw[SW_RELAY_CFG] && !next_q.motor_power);

        // polarity switch: on means active high
        next_q.brake_one = (brake_one_req == sw[SW_BRAKE_POL]);
        next_q.brake_two = (brake_two_req == sw[SW_BRAKE_POL]);

        next_q.uv_flag = sw[SW_UV_MON] && uv_seen;
        if (next_q.uv_flag && !q.uv_flag) begin
            events[EV_UNDER_VOLT] = 1'b1;
        end

        if (REG_WR && (REG_ADDR == REG_CONTROL)) begin
            next_q.soft_stop = REG_WDATA[CTRL_SOFT_STOP];
        end

        // read data stand only in the cycle after the strobe
        next_q.rdata = READ_ZERO;
        if (REG_RD) begin
            case (REG_ADDR)
                REG_IRQ_STATUS: begin
                    next_q.rdata = {{(DATA_W-EVENT_W){1'b0}}, irq_status};
                end
                REG_IRQ_ENABLE: begin
                    next_q.rdata = {{(DATA_W-EVENT_W){1'b0}}, irq_enable};
                end
                REG_LIVE_STATE: begin
                    next_q.rdata = live_state;
                end
                REG_SWITCHES: begin
                    next_q.rdata = sw;
                end
                REG_CONTROL: begin
                    next_q.rdata = {{(DATA_W-1){1'b0}}, q.soft_stop};
                end
                default: begin
                    next_q.rdata = READ_ZERO; // clear reg and holes
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            q.fsm <= FSM_RST;
            q.reset_prev <= 1'b0;
            q.settle <= '0;
            q.soft_stop <= CONTROL_SOFT_STOP_RST;
            q.motor_power <= 1'b0;
            q.logic_out <= 1'b0;
            q.relay_close <= 1'b0;
            q.brake_one <= 1'b0;
            q.brake_two <= 1'b0;
            q.uv_flag <= 1'b0;
            q.rdata <= READ_ZERO;
        end else if (CLK_EN) begin
            q <= next_q;
        end
    end

    // ==================================================================
    // live state word and interrupt block
    always_comb begin
        live_state = READ_ZERO;
        live_state[LS_MOTOR_POWER] = q.motor_power;
        live_state[LS_STOP_ACTIVE] = !q.motor_power;
        live_state[LS_INT_CLOSED] = int_ok;
        live_state[LS_EXT_CLOSED] = ext_ok;
        live_state[LS_UNDER_VOLT] = q.uv_flag;
        live_state[LS_RELAY_CLOSED] = q.relay_close;
        live_state[LS_BRAKE_ONE] = q.brake_one;
        live_state[LS_BRAKE_TWO] = q.brake_two;
    end

    assign clear_wr = REG_WR && (REG_ADDR == REG_IRQ_CLEAR);
    assign enable_wr = REG_WR && (REG_ADDR == REG_IRQ_ENABLE);

    event_irq u_irq (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .ce(CLK_EN),
        .event_in(events),
        .clear_wr(clear_wr),
        .enable_wr(enable_wr),
        .wdata(REG_WDATA[EVENT_W-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(IRQ)
    );

    assign REG_RDATA = q.rdata;
    assign MOTOR_POWER = q.motor_power;
    assign STOP_STATE_LOGIC_OUT = q.logic_out;
    assign RELAY_CLOSE = q.relay_close;
    assign BRAKE_ONE_DRIVE = q.brake_one;
    assign BRAKE_TWO_DRIVE = q.brake_two;
    assign UNDER_VOLTAGE_FLAG = q.uv_flag;

    // ==================================================================
    // checks
    property p_armed_holds;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        (q.fsm == ST_ARMED && sw[SW_RESET_CFG] && !reset_rise && !open_now)
        |=> (q.fsm == ST_ARMED) && !MOTOR_POWER;
    endproperty
    a_armed_holds: assert property (p_armed_holds)
        else $error("power returned without a reset closure");

    property p_armed_go;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        (q.fsm == ST_ARMED && reset_rise && !open_now) |=> MOTOR_POWER;
    endproperty
    a_armed_go: assert property (p_armed_go)
        else $error("reset closure did not restore power");

    property p_auto_restore;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        (q.fsm == ST_STOPPED && !sw[SW_RESET_CFG] && all_closed && !open_now)
        |=> MOTOR_POWER && $rose(MOTOR_POWER);
    endproperty
    a_auto_restore: assert property (p_auto_restore)
        else $error("power not restored once loops closed");

    property p_brake_level;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        rst_n |=> (BRAKE_ONE_DRIVE == $past(brake_one_req ~^ sw[SW_BRAKE_POL]))
            && (BRAKE_TWO_DRIVE == $past(brake_two_req ~^ sw[SW_BRAKE_POL]));
    endproperty
    a_brake_level: assert property (p_brake_level)
        else $error("brake drive does not match chosen polarity");

    property p_logic_out;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        STOP_STATE_LOGIC_OUT |-> MOTOR_POWER && $past(sw[SW_LOGIC_CFG]);
    endproperty
    a_logic_out: assert property (p_logic_out)
        else $error("logic output high without power or switch");

    property p_relay_opens;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        (sw[SW_RELAY_CFG] && open_now) |=> !RELAY_CLOSE && !MOTOR_POWER;
    endproperty
    a_relay_opens: assert property (p_relay_opens)
        else $error("relay stayed closed during a stop");

    property p_int_loop;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        (sw[SW_INT_STOP] && !int_ok) |=> !MOTOR_POWER;
    endproperty
    a_int_loop: assert property (p_int_loop)
        else $error("power on with internal loop open");

    property p_ext_loop;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        (sw[SW_EXT_STOP] && !ext_ok) |=> !MOTOR_POWER;
    endproperty
    a_ext_loop: assert property (p_ext_loop)
        else $error("power on with external loop open");

    property p_uv_gated;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        UNDER_VOLTAGE_FLAG |-> $past(sw[SW_UV_MON]) && $past(uv_seen);
    endproperty
    a_uv_gated: assert property (p_uv_gated)
        else $error("under-voltage reported while monitor off");

    property p_relay_ctl;
        @(posedge SYS_CLK) disable iff (!rst_n || !CLK_EN)
        (!sw[SW_RELAY_CFG] && !open_now) |=> (RELAY_CLOSE == $past(relay_req));
    endproperty
    a_relay_ctl: assert property (p_relay_ctl)
        else $error("relay does not follow its control input");

endmodule : estop_brake_interlock

`default_nettype wire

// [sim/field_side.sv]
`default_nettype none

// ==================================================================
// field wiring: stop loops, reset contact, brake sources, relay, sense
module field_side (
    input wire logic clk,
    input wire logic [6:0] want,
    output logic [6:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // contacts start open so nothing looks closed before the bench says so
    initial pins = 7'h00;

    // loops report closed only while the bench holds them closed
    always @(posedge clk) begin
        pins[0] <= want[0];
        pins[1] <= want[1];
        pins[6:2] <= want[6:2];
    end
endmodule : field_side

`default_nettype wire

// [sim/estop_brake_interlock_tb_top.sv]
`default_nettype none

module estop_brake_interlock_tb_top
    import estop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // short debounce keeps the run small
    localparam int FC = 8;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [6:0] want = 7'h23;
    logic [SW_W-1:0] sw = 8'h7E;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic [DATA_W-1:0] rdata;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic mp, lo, rc, b1, b2, uvf, irq;
    logic [6:0] pins;
    int err_count = 0;
    int n_checks = 0;
    int p, v;

    always #2 clk = ~clk;

    field_side i_field (.clk(clk), .want(want), .pins(pins));

    estop_brake_interlock #(.FILTER_CYCLES(FC)) i_dut (
        .SYS_CLK(clk), .RSTN(rstn), .CLK_EN(1'b1),
        .INTERNAL_STOP_LOOP(pins[0]), .EXTERNAL_STOP_LOOP(pins[1]),
        .STOP_RESET_CLOSURE(pins[2]), .BRAKE_ONE_REQUEST(pins[3]),
        .BRAKE_TWO_REQUEST(pins[4]), .RELAY_CONTROL(pins[5]),
        .UNDER_VOLTAGE_SENSE(pins[6]), .CONFIG_SWITCH_BANK(sw),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_RDATA(rdata), .MOTOR_POWER(mp), .STOP_STATE_LOGIC_OUT(lo),
        .RELAY_CLOSE(rc), .BRAKE_ONE_DRIVE(b1), .BRAKE_TWO_DRIVE(b2),
        .UNDER_VOLTAGE_FLAG(uvf), .IRQ(irq)
    );

    // ==================================================================
    // helpers
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // outputs are looked at mid-cycle, clear of the edge updates
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : tick

    task automatic set(input logic [6:0] w, input logic [7:0] s);
        @(posedge clk);
        want <= w;
        sw <= s;
    endtask : set

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, e, "read");
    endtask : rd

    // bounded wait for the power state; a run-out ends the run
    task automatic wait_pw(input logic e);
        int i;
        for (i = 0; i < 80 && mp !== e; i++) @(negedge clk);
        if (i == 80) begin
            err_count++;
            $display("FAIL %0t power wait ran out", $time);
            close_out();
        end
        chk({7'h00, mp}, {7'h00, e}, "power");
    endtask : wait_pw

    // ==================================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        wait_pw(1'b1);
        chk({6'h00, lo, rc}, 8'h03, "logic relay");
        wr(REG_IRQ_CLEAR, 8'h0F);
        wr(REG_IRQ_ENABLE, 8'h01);
        rd(REG_IRQ_STATUS, 8'h00);
        rd(4'hF, 8'h00);
        rd(REG_SWITCHES, 8'h7E);
        rd(REG_LIVE_STATE, 8'h2D);
        $display("test power_up done");
        set(7'h22, 8'h7E);
        wait_pw(1'b0);
        chk({6'h00, rc, irq}, 8'h01, "relay irq");
        rd(REG_IRQ_STATUS, 8'h01);
        wr(REG_IRQ_CLEAR, 8'h01);
        tick(2);
        chk({7'h00, irq}, 8'h00, "irq cleared");
        set(7'h23, 8'h7E);
        wait_pw(1'b1);
        set(7'h21, 8'h76);
        wait_pw(1'b0);
        tick(20);
        chk({7'h00, rc}, 8'h01, "relay free");
        set(7'h23, 8'h6E);
        wait_pw(1'b1);
        set(7'h22, 8'h6E);
        tick(40);
        chk({7'h00, mp}, 8'h01, "int unused");
        $display("test loops done");
        set(7'h21, 8'h7F);
        wait_pw(1'b0);
        set(7'h23, 8'h7F);
        tick(40);
        chk({7'h00, mp}, 8'h00, "armed");
        set(7'h27, 8'h7F);
        tick(3);
        set(7'h23, 8'h7F);
        tick(30);
        chk({7'h00, mp}, 8'h00, "short closure");
        set(7'h27, 8'h7F);
        tick(20);
        set(7'h23, 8'h7F);
        wait_pw(1'b1);
        wr(REG_CONTROL, 8'h01);
        wait_pw(1'b0);
        rd(REG_CONTROL, 8'h01);
        wr(REG_CONTROL, 8'h00);
        set(7'h23, 8'h7A);
        wait_pw(1'b1);
        tick(30);
        chk({7'h00, lo}, 8'h00, "logic off");
        $display("test reset done");
        set(7'h03, 8'h7E);
        tick(30);
        chk({7'h00, rc}, 8'h00, "relay ctl");
        set(7'h63, 8'h7E);
        tick(30);
        chk({7'h00, uvf}, 8'h01, "uv on");
        rd(REG_IRQ_STATUS, 8'h07);
        set(7'h63, 8'h3E);
        tick(30);
        chk({7'h00, uvf}, 8'h00, "uv off");
        for (p = 0; p < 2; p++) begin
            for (v = 0; v < 4; v++) begin
                set({2'b01, v[1], v[0], 3'b011}, p[0] ? 8'h7E : 8'h7C);
                tick(30);
                chk({6'h00, b2, b1}, {6'h00, ~(v[1] ^ p[0]),
                    ~(v[0] ^ p[0])}, "brake");
            end
        end
        $display("test io done");
        close_out();
    end
endmodule : estop_brake_interlock_tb_top

`default_nettype wire
